// [design/autx_pkg.sv]
// Purpose: shared constants and register layouts of the serial port
// Assumes: 32-bit APB data, one register per aligned word
// Notes:   bit layouts are packed structs, MSB first
package autx_pkg;

	localparam logic [7:0] OFF_TXCTL  = 8'h00;
	localparam logic [7:0] OFF_BAUDCTL = 8'h04;
	localparam logic [7:0] OFF_DIVLO  = 8'h08;
	localparam logic [7:0] OFF_DIVHI  = 8'h0C;
	localparam logic [7:0] OFF_TXBUF  = 8'h10;
	localparam logic [7:0] OFF_RXBUF  = 8'h14;
	localparam logic [7:0] OFF_PORTCTL = 8'h18;
	localparam logic [7:0] OFF_STATUS = 8'h1C;

	// Transmit control register, bit 4 sync select, bit 1 shifter empty
	typedef struct packed {
		logic rsvd7;
		logic nineBitTransmit;
		logic transmitEnable;
		logic syncSelect;
		logic rsvd3;
		logic highSpeedSelect;
		logic shifterEmpty;
		logic ninthTransmitBit;
	} autx_txctl_s;

	// Baud control register, bit 7 overflow, bit 0 auto-baud enable
	typedef struct packed {
		logic autobaudOverflow;
		logic rsvd6;
		logic rsvd5;
		logic rsvd4;
		logic wideDividerSelect;
		logic rsvd2;
		logic wakeOnBreakEnable;
		logic autobaudEnable;
	} autx_baudctl_s;

	localparam logic [7:0] TXCTL_RST   = 8'h02;
	localparam logic [7:0] BAUDCTL_RST = 8'h00;
	localparam logic [7:0] DIV_RST     = 8'h00;
	localparam int PORT_EN_BIT  = 7;
	localparam int IRQ_EN_BIT   = 0;
	localparam int ST_TXE_BIT   = 0;
	localparam int ST_RXD_BIT   = 1;

	// Bit period in baud ticks, minus one: x64, x16, x4
	localparam logic [5:0] MULT64_M1 = 6'h3F;
	localparam logic [5:0] MULT16_M1 = 6'h0F;
	localparam logic [5:0] MULT4_M1  = 6'h03;
	// Measurement clock dividers, minus one: 512, 128, 32
	localparam logic [8:0] PRE512_M1 = 9'h1FF;
	localparam logic [8:0] PRE128_M1 = 9'h07F;
	localparam logic [8:0] PRE32_M1  = 9'h01F;
	localparam logic [2:0] ABD_LAST_EDGE = 3'h5;
	localparam logic [3:0] LAST_BIT8 = 4'h7;
	localparam logic [3:0] LAST_BIT9 = 4'h8;

	typedef enum logic [4:0] {
		AB_IDLE  = 5'h01,
		AB_BRKLO = 5'h02,
		AB_BRKHI = 5'h04,
		AB_START = 5'h08,
		AB_COUNT = 5'h10
	} autx_ab_e;

	typedef enum logic [3:0] {
		TX_IDLE  = 4'h1,
		TX_START = 4'h2,
		TX_DATA  = 4'h4,
		TX_STOP  = 4'h8
	} autx_tx_e;

endpackage

// [design/autx_core.sv]
// Purpose: asynchronous transmitter with baud generator and auto-baud
// Assumes: receiveLine is synchronous to mclk; APB slave, one wait state
// Notes:   receive data path is absent; receive buffer reads as zero
// Summary of operation
// - Auto-baud arms only in asynchronous mode with the port enable bit set.
// - Arming auto-baud clears the divisor, then waits for a start bit.
// - Counting begins on first rising receive edge after start bit.
// - Fifth rising edge leaves the period in divisor, enable self-clears.
// - Counter rollover sets overflow bit 7; measurement continues.
// - Measurement counts at one eighth of the baud clock rate.
// - Measurement clock is mclk over 512, 128 or 32.
// - Sixteen-bit divisor only with wide select; high byte shows carry.
// - No reception happens while auto-baud runs.
// - Fifth edge sets receive-done; reading receive buffer clears it.
// - With wake-up enable, measure the character after the break.
// - Sync select bit 4 clear selects async: start, 8/9 data, stop.
// - LSB first; common frame format and baud rate.
// - Bit period is 64, 16 or 4 baud ticks per select bits.
// - No hardware parity; ninth bit carries any parity.
// - Shifter reloads only after stop bit, at once if buffer full.
// - Buffer-to-shifter transfer sets buffer-empty flag; writes cannot clear.
// - Buffer-empty flag clears on second cycle after buffer write.
// - Read-only shifter-empty bit 1 shows the shifter is idle.
// - Ninth bit taken at buffer write; enabling sets buffer-empty flag.
`timescale 1ns/1ns
module autx_core
	import autx_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        receiveLine,
	output logic             transmitLine
);

	autx_txctl_s   txCtl_r;
	autx_baudctl_s baudCtl_r;
	autx_ab_e      abState_r;
	autx_tx_e      txState_r;
	logic [7:0]    divLo_r;
	logic [7:0]    divHi_r;
	logic          portEnable_r;
	logic          irqEnable_r;
	logic          rxDone_r;
	logic          rxPrev_r;
	logic [2:0]    edgeCnt_r;
	logic [8:0]    preCnt_r;
	logic [15:0]   divCnt_r;
	logic [5:0]    subCnt_r;
	logic [8:0]    txBuf_r;
	logic          txFull_r;
	logic [8:0]    shift_r;
	logic [3:0]    bitCnt_r;
	logic          txEmptyFlag_r;
	logic [31:0]   prdata_r;
	logic          pready_r;
	logic          pslverr_r;
	logic          txLine_r;

	// Bus decode
	wire        setupDone = psel & penable & ~pready_r;
	wire        apbAcc    = psel & penable & pready_r;
	wire        apbWr     = apbAcc & pwrite;
	wire        wrTxCtl   = apbWr & (paddr == OFF_TXCTL);
	wire        wrBaudCtl = apbWr & (paddr == OFF_BAUDCTL);
	wire        wrDivLo   = apbWr & (paddr == OFF_DIVLO);
	wire        wrDivHi   = apbWr & (paddr == OFF_DIVHI);
	wire        wrTxBuf   = apbWr & (paddr == OFF_TXBUF);
	wire        wrPortCtl = apbWr & (paddr == OFF_PORTCTL);
	wire        rdRxBuf   = apbAcc & ~pwrite & (paddr == OFF_RXBUF);
	wire        mapped    = (paddr[7:5] == 3'h0) & (paddr[1:0] == 2'h0);
	wire [7:0]  wrByte    = pwdata[7:0];

	// Receive line edges
	wire        rxFall = rxPrev_r & ~receiveLine;
	wire        rxRise = ~rxPrev_r & receiveLine;
	wire        asyncOn = portEnable_r & ~txCtl_r.syncSelect;

	// Auto-baud control
	wire        abArm  = (abState_r == AB_IDLE) & baudCtl_r.autobaudEnable
	                     & asyncOn;
	wire        abBusy = (abState_r != AB_IDLE);
	wire [1:0]  rateSel = {baudCtl_r.wideDividerSelect,
	                       txCtl_r.highSpeedSelect};
	wire [8:0]  preLim = (rateSel == 2'b00) ? PRE512_M1 :
	                     (rateSel == 2'b11) ? PRE32_M1 : PRE128_M1;
	wire        preTick = (abState_r == AB_COUNT) & (preCnt_r == preLim);
	wire [15:0] measure = {divHi_r, divLo_r};
	wire        abOvf   = preTick & (measure == 16'hFFFF);
	wire        abDone  = (abState_r == AB_COUNT) & rxRise
	                      & (edgeCnt_r == ABD_LAST_EDGE - 3'h1);
	wire        abAbort = abBusy & ~baudCtl_r.autobaudEnable;

	// Baud generator; 8-bit modes ignore the high byte
	wire [15:0] divEff  = baudCtl_r.wideDividerSelect ? measure
	                      : {8'h00, divLo_r};
	wire [5:0]  multM1  = (rateSel == 2'b00) ? MULT64_M1 :
	                      (rateSel == 2'b11) ? MULT4_M1 : MULT16_M1;
	wire        genRun  = (txState_r != TX_IDLE) & ~abBusy;
	wire        subTick = genRun & (divCnt_r == divEff);
	wire        bitTick = subTick & (subCnt_r == multM1);

	// Transmitter
	wire        loadOk = txFull_r & txCtl_r.transmitEnable & asyncOn & ~abBusy;
	wire [3:0]  lastBit = txCtl_r.nineBitTransmit ? LAST_BIT9 : LAST_BIT8;
	wire        stopEnd = (txState_r == TX_STOP) & bitTick;
	wire        load = loadOk & ((txState_r == TX_IDLE) | stopEnd);

	wire [31:0] rdMux =
		(paddr == OFF_TXCTL)   ? {24'h0, txCtl_r} :
		(paddr == OFF_BAUDCTL) ? {24'h0, baudCtl_r} :
		(paddr == OFF_DIVLO)   ? {24'h0, divLo_r} :
		(paddr == OFF_DIVHI)   ? {24'h0, divHi_r} :
		(paddr == OFF_PORTCTL) ? {24'h0, portEnable_r, 6'h00, irqEnable_r} :
		(paddr == OFF_STATUS)  ? {30'h0, rxDone_r, txEmptyFlag_r} :
		32'h0;

	// APB slave, one wait state
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h0;
		end else begin
			pready_r  <= setupDone;
			pslverr_r <= setupDone & ~mapped;
			if (setupDone & ~pwrite)
				prdata_r <= rdMux;
		end
	end

	// Software control bits; shifter-empty is hardware owned
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			txCtl_r      <= autx_txctl_s'(TXCTL_RST);
			portEnable_r <= 1'b0;
			irqEnable_r  <= 1'b0;
		end else begin
			if (wrTxCtl) begin
				txCtl_r.nineBitTransmit  <= wrByte[6];
				txCtl_r.transmitEnable   <= wrByte[5];
				txCtl_r.syncSelect       <= wrByte[4];
				txCtl_r.highSpeedSelect  <= wrByte[2];
				txCtl_r.ninthTransmitBit <= wrByte[0];
			end
			txCtl_r.shifterEmpty <= (txState_r == TX_IDLE);
			if (wrPortCtl) begin
				portEnable_r <= wrByte[PORT_EN_BIT];
				irqEnable_r  <= wrByte[IRQ_EN_BIT];
			end
		end
	end

	// Baud control: hardware set of overflow wins over a software clear
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			baudCtl_r <= autx_baudctl_s'(BAUDCTL_RST);
		end else begin
			if (wrBaudCtl) begin
				baudCtl_r.wideDividerSelect <= wrByte[3];
				baudCtl_r.wakeOnBreakEnable <= wrByte[1];
				baudCtl_r.autobaudEnable    <= wrByte[0];
				baudCtl_r.autobaudOverflow  <= wrByte[7];
			end
			if (abOvf)
				baudCtl_r.autobaudOverflow <= 1'b1;
			if (abDone)
				baudCtl_r.autobaudEnable <= 1'b0;
		end
	end

	// Receive-done: set wins over the clearing read
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rxDone_r <= 1'b0;
			rxPrev_r <= 1'b1;
		end else begin
			rxPrev_r <= receiveLine;
			if (abDone)
				rxDone_r <= 1'b1;
			else if (rdRxBuf)
				rxDone_r <= 1'b0;
		end
	end

	// Auto-baud sequencer; no receive path runs meanwhile
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			abState_r <= AB_IDLE;
			edgeCnt_r <= 3'h0;
		end else if (abAbort) begin
			abState_r <= AB_IDLE;
		end else begin
			unique case (abState_r)
			AB_IDLE: begin
				if (abArm)
					abState_r <= baudCtl_r.wakeOnBreakEnable
					             ? AB_BRKLO : AB_START;
			end
			AB_BRKLO: begin
				if (rxFall)
					abState_r <= AB_BRKHI;
			end
			AB_BRKHI: begin
				if (rxRise)
					abState_r <= AB_START;
			end
			AB_START: begin
				if (rxFall)
					abState_r <= AB_COUNT;
				edgeCnt_r <= 3'h0;
			end
			AB_COUNT: begin
				if (abDone)
					abState_r <= AB_IDLE;
				else if (rxRise)
					edgeCnt_r <= edgeCnt_r + 3'h1;
			end
			endcase
		end
	end

	// Measurement prescaler; starts on the first rising edge
	wire counting = (abState_r == AB_COUNT) & (edgeCnt_r != 3'h0);
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			preCnt_r <= 9'h000;
		else if (!counting || preTick)
			preCnt_r <= 9'h000;
		else
			preCnt_r <= preCnt_r + 9'h001;
	end

	// Divisor pair: cleared on arming, counts while measuring
	wire [15:0] measureInc = measure + 16'h0001;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			divLo_r <= DIV_RST;
			divHi_r <= DIV_RST;
		end else if (abArm) begin
			divLo_r <= 8'h00;
			divHi_r <= 8'h00;
		end else if (preTick && counting) begin
			{divHi_r, divLo_r} <= measureInc;
		end else if (!abBusy) begin
			if (wrDivLo)
				divLo_r <= wrByte;
			if (wrDivHi)
				divHi_r <= wrByte;
		end
	end

	// Baud tick generator, held clear while idle so each frame starts aligned
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			divCnt_r <= 16'h0000;
			subCnt_r <= 6'h00;
		end else if (!genRun) begin
			divCnt_r <= 16'h0000;
			subCnt_r <= 6'h00;
		end else if (subTick) begin
			divCnt_r <= 16'h0000;
			subCnt_r <= bitTick ? 6'h00 : subCnt_r + 6'h01;
		end else begin
			divCnt_r <= divCnt_r + 16'h0001;
		end
	end

	// Holding buffer; a write in the load cycle still lands
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			txBuf_r  <= 9'h000;
			txFull_r <= 1'b0;
		end else if (wrTxBuf) begin
			txBuf_r  <= {txCtl_r.ninthTransmitBit, wrByte};
			txFull_r <= 1'b1;
		end else if (load) begin
			txFull_r <= 1'b0;
		end
	end

	// Flag follows the buffer one cycle late; software cannot write it
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			txEmptyFlag_r <= 1'b0;
		else
			txEmptyFlag_r <= txCtl_r.transmitEnable & ~txFull_r;
	end

	// Shifter state machine
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			txState_r <= TX_IDLE;
			shift_r   <= 9'h1FF;
			bitCnt_r  <= 4'h0;
		end else begin
			unique case (txState_r)
			TX_IDLE: begin
				if (load) begin
					txState_r <= TX_START;
					shift_r   <= txBuf_r;
				end
			end
			TX_START: begin
				if (bitTick) begin
					txState_r <= TX_DATA;
					bitCnt_r  <= 4'h0;
				end
			end
			TX_DATA: begin
				if (bitTick) begin
					shift_r  <= {1'b1, shift_r[8:1]};
					bitCnt_r <= bitCnt_r + 4'h1;
					if (bitCnt_r == lastBit)
						txState_r <= TX_STOP;
				end
			end
			TX_STOP: begin
				if (load) begin
					txState_r <= TX_START;
					shift_r   <= txBuf_r;
				end else if (stopEnd) begin
					txState_r <= TX_IDLE;
				end
			end
			endcase
		end
	end

	// Line drive: registered, so it trails the state by one cycle
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			txLine_r <= 1'b1;
		else
			txLine_r <= (txState_r == TX_START) ? 1'b0 :
			            (txState_r == TX_DATA) ? shift_r[0] : 1'b1;
	end

	assign prdata       = prdata_r;
	assign pready       = pready_r;
	assign pslverr      = pslverr_r;
	assign transmitLine = txLine_r;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	a_start_bit_low: assert property (
		txState_r == TX_START |=> !transmitLine)
		else $error("start bit not low");
	a_data_lsb_first: assert property (
		txState_r == TX_DATA |=> transmitLine == $past(shift_r[0]))
		else $error("data bit not lsb first");
	a_reload_stop: assert property (
		stopEnd && loadOk && !wrTxBuf |=> txState_r == TX_START && !txFull_r)
		else $error("no reload after stop bit");
	a_flag_clear_late: assert property (
		wrTxBuf && txCtl_r.transmitEnable && !wrTxCtl && !$past(load)
		|=> txEmptyFlag_r == $past(txEmptyFlag_r) ##1 !txEmptyFlag_r)
		else $error("empty flag timing wrong");
	a_flag_set_load: assert property (
		load && !wrTxBuf && !wrTxCtl ##1 !wrTxCtl |=> txEmptyFlag_r)
		else $error("empty flag not set after transfer");
	a_arm_clears_div: assert property (
		abArm |=> divLo_r == 8'h00 && divHi_r == 8'h00 && abBusy)
		else $error("divisor not cleared on arming");
	a_abd_finish: assert property (
		abDone |=> !baudCtl_r.autobaudEnable && abState_r == AB_IDLE)
		else $error("auto-baud did not finish");
	a_abd_rxdone: assert property (
		abDone |=> rxDone_r)
		else $error("receive done not set");
	a_ovf_keeps_on: assert property (
		abOvf && !abDone && !wrBaudCtl |=> baudCtl_r.autobaudOverflow
		&& baudCtl_r.autobaudEnable && measure == 16'h0000)
		else $error("overflow handling wrong");
	a_abd_gated_sync: assert property (
		abState_r == AB_IDLE && txCtl_r.syncSelect |=> abState_r == AB_IDLE)
		else $error("auto-baud ran in sync mode");

	c_back_to_back: cover property (stopEnd && loadOk);
	c_abd_done: cover property (abDone);
	c_abd_overflow: cover property (abOvf);
	c_nine_bit: cover property (stopEnd && txCtl_r.nineBitTransmit);

endmodule

// [sim/autx_remote_node.sv]
// Purpose: remote serial node: sends calibration and break, decodes frames
// Assumes: line timing counted in mclk cycles, bitCycles for decoding, task argument t for sending
// Notes:   decoded frames queue as {stopOk, bit8, data}
`timescale 1ns/1ns
module autx_remote_node (
	input  wire logic        mclk,
	input  wire logic        txLine,
	input  wire logic [15:0] bitCycles,
	input  wire logic        nineBits,
	output logic             rxLine
);
	logic [9:0] rxq[$];

	initial rxLine = 1'b1;

	task automatic holdLine(input logic v, input int cyc);
		rxLine <= v;
		repeat (cyc) @(posedge mclk);
	endtask

	// Alternating bits give equal low and high times to measure
	task automatic sendCal(input int t);
		holdLine(1'b0, t);
		for (int i = 0; i < 8; i++)
			holdLine(~i[0], t);
		holdLine(1'b1, t);
	endtask

	task automatic sendBreak(input int t);
		holdLine(1'b0, 13 * t);
		holdLine(1'b1, t);
	endtask

	// Samples mid-bit; a bad start bit is folded into stopOk
	always begin
		logic [9:0] f;
		int         nb;
		@(negedge txLine);
		repeat (bitCycles / 2) @(posedge mclk);
		f = '0;
		f[9] = ~txLine;
		nb = nineBits ? 9 : 8;
		for (int i = 0; i <= nb; i++) begin
			repeat (bitCycles) @(posedge mclk);
			if (i < nb)
				f[i] = txLine;
			else
				f[9] = f[9] & txLine;
		end
		rxq.push_back(f);
	end
endmodule

// [sim/tb_autx_core.sv]
// Purpose: self-checking bench for the serial transmitter and auto-baud
// Assumes: APB master with one wait state, partner model on the line
// Notes:   random bytes and divisors from a fixed seed
`timescale 1ns/1ns
module tb_autx_core
	import autx_pkg::*;
;
	logic        mclk;
	logic        rst_n;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        receiveLine;
	logic        transmitLine;
	logic [15:0] bitCycles;
	logic        nineBits;
	logic [31:0] r;
	logic        e;
	logic [9:0]  f;
	int          err_count;
	int          n_compared;

	autx_core u_autx_core (.mclk(mclk), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .receiveLine(receiveLine),
		.transmitLine(transmitLine));

	autx_remote_node u_autx_remote_node (.mclk(mclk),
		.txLine(transmitLine), .bitCycles(bitCycles),
		.nineBits(nineBits), .rxLine(receiveLine));

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	function automatic logic [15:0] bitLen(input logic w, input logic h,
		input int d);
		return 16'((w & h ? 4 : (w | h ? 16 : 64)) * (d + 1));
	endfunction

	// Count runs at mclk/p over eight bit times; edges cost one tick
	function automatic logic abdNear(input logic [31:0] v, input int t,
		input int p);
		int x;
		x = 8 * t / p;
		return (int'(v) >= x - 1) && (int'(v) <= x + 1);
	endfunction

	task automatic fail(input string s);
		err_count++;
		$display("unexpected at %0t: %s", $time, s);
	endtask

	task automatic chkReg(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
			fail($sformatf("reg %h exp %h", got, exp));
	endtask

	task automatic chkBit(input logic got, input logic exp);
		n_compared++;
		if (got !== exp)
			fail($sformatf("bit %b exp %b", got, exp));
	endtask

	task automatic chkFrame(input logic [9:0] got, input logic [9:0] exp);
		n_compared++;
		if (got !== exp)
			fail($sformatf("frame %h exp %h", got, exp));
	endtask

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		@(posedge mclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 40);
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (n >= 40)
			fail("no pready");
	endtask

	task automatic waitFrames(input int n);
		int k;
		k = 0;
		while (u_autx_remote_node.rxq.size() < n && k < 30000) begin
			@(posedge mclk);
			k++;
		end
		if (k >= 30000)
			fail("frame missing");
	endtask

	task automatic done(input string s);
		$display("test %s done", s);
	endtask

	task automatic end_sim;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		repeat (90000) @(posedge mclk);
		fail("watchdog");
		end_sim;
	end

	initial begin
		int         d;
		int         t;
		int         p;
		logic [7:0] b [2];
		void'($urandom(32'hA471));
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		bitCycles = 16'h0040;
		nineBits = 1'b0;
		rst_n = 1'b0;
		repeat (12) @(posedge mclk);
		rst_n <= 1'b1;
		chkBit(transmitLine, 1'b1);
		apb(0, OFF_TXCTL, 0);
		chkReg(r, {24'h0, TXCTL_RST});
		apb(0, OFF_BAUDCTL, 0);
		chkReg(r, {24'h0, BAUDCTL_RST});
		apb(0, 8'h20, 0);
		chkBit(e, 1'b1);
		chkReg(r, 32'h0);
		apb(1, OFF_PORTCTL, 32'h80);
		apb(1, OFF_TXCTL, 32'h20);
		apb(0, OFF_STATUS, 0);
		chkReg(r, 32'h1);
		done("reset");
		for (int c = 0; c < 4; c++) begin
			d = $urandom_range(2, 0);
			bitCycles = bitLen(c[1], c[0], d);
			apb(1, OFF_DIVLO, d);
			apb(1, OFF_BAUDCTL, c[1] ? 32'h08 : 32'h00);
			apb(1, OFF_TXCTL, c[0] ? 32'h24 : 32'h20);
			b[0] = 8'($urandom);
			b[1] = 8'($urandom);
			apb(1, OFF_TXBUF, {24'h0, b[0]});
			apb(1, OFF_TXBUF, {24'h0, b[1]});
			apb(0, OFF_STATUS, 0);
			chkReg(r, 32'h0);
			apb(0, OFF_TXCTL, 0);
			chkBit(r[1], 1'b0);
			waitFrames(2);
			for (int i = 0; i < 2; i++) begin
				f = u_autx_remote_node.rxq.pop_front();
				chkFrame(f, {2'b10, b[i]});
			end
			repeat (bitCycles) @(posedge mclk);
			apb(0, OFF_TXCTL, 0);
			chkBit(r[1], 1'b1);
			apb(0, OFF_STATUS, 0);
			chkReg(r, 32'h1);
		end
		done("baud configs");
		nineBits = 1'b1;
		for (int n = 0; n < 2; n++) begin
			b[0] = 8'($urandom);
			apb(1, OFF_TXCTL, n ? 32'h65 : 32'h64);
			apb(1, OFF_TXBUF, {24'h0, b[0]});
			waitFrames(1);
			f = u_autx_remote_node.rxq.pop_front();
			chkFrame(f, {1'b1, n[0], b[0]});
			repeat (bitCycles) @(posedge mclk);
		end
		nineBits = 1'b0;
		done("nine bit");
		// Third pass uses the mclk/128 measurement clock
		for (int w = 0; w < 3; w++) begin
			p = (w == 2) ? 128 : 32;
			t = 5 * p + $urandom_range(5 * p, 0);
			apb(1, OFF_TXCTL, (w == 2) ? 32'h20 : 32'h24);
			apb(1, OFF_DIVLO, 32'h5A);
			apb(1, OFF_BAUDCTL, (w == 1) ? 32'h0B : 32'h09);
			apb(0, OFF_DIVLO, 0);
			chkReg(r, 32'h0);
			if (w == 1)
				u_autx_remote_node.sendBreak(t);
			u_autx_remote_node.sendCal(t);
			apb(0, OFF_BAUDCTL, 0);
			chkBit(r[0], 1'b0);
			apb(0, OFF_STATUS, 0);
			chkBit(r[1], 1'b1);
			apb(0, OFF_DIVLO, 0);
			chkBit(abdNear(r, t, p), 1'b1);
			apb(0, OFF_DIVHI, 0);
			chkReg(r, 32'h0);
			apb(0, OFF_RXBUF, 0);
			apb(0, OFF_STATUS, 0);
			chkBit(r[1], 1'b0);
		end
		apb(1, OFF_BAUDCTL, 32'h88);
		apb(0, OFF_BAUDCTL, 0);
		chkReg(r, 32'h88);
		apb(1, OFF_BAUDCTL, 32'h08);
		apb(0, OFF_BAUDCTL, 0);
		chkReg(r, 32'h08);
		done("autobaud");
		apb(1, OFF_TXCTL, 32'h34);
		apb(1, OFF_TXBUF, 32'hA5);
		repeat (20) @(posedge mclk);
		chkBit(transmitLine, 1'b1);
		done("sync select");
		end_sim;
	end
endmodule
